// ===== hdl/rid_alu.sv
`timescale 1ns/1ps
`default_nettype none
module rid_alu (
  input wire rid_pkg::rid_alu_t op, // Operation
  input wire logic [7:0] a, // Accumulator
  input wire logic [7:0] b, // File value or literal
  input wire logic cin, // Carry in
  input wire logic [2:0] bsel, // Bit number
  output logic [7:0] res, // Result
  output logic cout, // Carry out
  output logic dcout // Nibble carry out
);
  logic [8:0] s;
  logic [4:0] h;

  // Subtract is b - a; carry set means no borrow
  always_comb
  begin
    s = 9'h000;
    h = 5'h00;
    res = b;
    cout = cin;
    dcout = 1'b0;
    unique case (op)
      rid_pkg::A_PASS_A: res = a;
      rid_pkg::A_PASS_B: res = b;
      rid_pkg::A_ZERO: res = 8'h00;
      rid_pkg::A_ADD:
      begin
        s = {1'b0, b} + {1'b0, a};
        h = {1'b0, b[3:0]} + {1'b0, a[3:0]};
      end
      rid_pkg::A_SUB:
      begin
        s = {1'b0, b} + {1'b0, ~a} + 9'h001;
        h = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
      end
      rid_pkg::A_INC: res = b + 8'h01;
      rid_pkg::A_DEC: res = b - 8'h01;
      rid_pkg::A_IOR: res = a | b;
      rid_pkg::A_AND: res = a & b;
      rid_pkg::A_XOR: res = a ^ b;
      rid_pkg::A_COM: res = ~b;
      rid_pkg::A_RR:
      begin
        res = {cin, b[7:1]};
        cout = b[0];
      end
      rid_pkg::A_RL:
      begin
        res = {b[6:0], cin};
        cout = b[7];
      end
      rid_pkg::A_SWAP: res = {b[3:0], b[7:4]};
      rid_pkg::A_BCLR: res = b & ~(8'h01 << bsel);
      rid_pkg::A_BSET: res = b | (8'h01 << bsel);
    endcase
    if (op == rid_pkg::A_ADD || op == rid_pkg::A_SUB)
    begin
      res = s[7:0];
      cout = s[8];
      dcout = h[4];
    end
  end
endmodule : rid_alu
`default_nettype wire

// ===== hdl/rid_core.sv
`timescale 1ns/1ps
`default_nettype none
module rid_core (
  input wire logic clock, // Core oscillator
  input wire logic rstn, // Reset, active low
  input wire logic [13:0] instr, // Word at prog_addr
  input wire logic [1:0] page, // Upper jump target bits
  output logic [12:0] prog_addr, // Fetch address
  output logic [6:0] file_addr, // File register address
  output logic file_rd, // File read strobe
  input wire logic [7:0] file_rdata, // File read data
  input wire logic [7:0] port_b_pins, // Port pin levels
  output logic port_read, // Port read happened
  output logic file_we, // File write strobe
  output logic [7:0] file_wdata, // File write data
  output logic [7:0] acc, // Working accumulator
  output logic [2:0] status, // Z, DC, C
  output var rid_pkg::rid_phase_t phase, // Current phase
  output logic nop_cycle, // Flushed cycle
  output var rid_pkg::rid_evt_t evt // Control pulses
);
  logic rst_meta_q;
  logic rst_n;
  rid_pkg::rid_phase_t phase_q;
  logic [13:0] ir_q;
  logic flush_q;
  logic [12:0] pc_q;
  logic [12:0] stack_q [rid_pkg::STACK_D];
  logic [2:0] sp_q;
  logic [6:0] file_addr_q;
  logic file_rd_q;
  logic port_read_q;
  logic file_we_q;
  logic [7:0] file_wdata_q;
  logic [7:0] opnd_q;
  logic [7:0] w_q;
  logic [2:0] status_q;
  rid_pkg::rid_evt_t evt_q;
  rid_pkg::rid_dec_t dec;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic exec;
  logic branch;
  logic skip;
  logic taken;
  logic is_q4;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  rid_fields u_fields (
    .instr(ir_q),
    .dec(dec)
  );

  assign alu_b = dec.use_k ? dec.k8 : opnd_q;

  rid_alu u_alu (
    .op(dec.alu),
    .a(w_q),
    .b(alu_b),
    .cin(status_q[rid_pkg::ST_C]),
    .bsel(dec.b),
    .res(alu_res),
    .cout(alu_c),
    .dcout(alu_dc)
  );

  // A flushed cycle runs as an empty slot
  assign exec = !flush_q;
  assign is_q4 = phase_q == rid_pkg::PH_Q4;
  assign branch = dec.kind inside {rid_pkg::K_CALL, rid_pkg::K_GOTO,
    rid_pkg::K_RET, rid_pkg::K_RETFIE, rid_pkg::K_RETLW};
  assign skip = (dec.skip_z && alu_res == 8'h00) ||
    (dec.skip_bit && opnd_q[dec.b] == dec.skip_set);
  assign taken = exec && (branch || skip);

  // Phase sequencer, one step per oscillator period
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_q <= rid_pkg::PH_Q1;
    else
      unique case (phase_q)
        rid_pkg::PH_Q1: phase_q <= rid_pkg::PH_Q2;
        rid_pkg::PH_Q2: phase_q <= rid_pkg::PH_Q3;
        rid_pkg::PH_Q3: phase_q <= rid_pkg::PH_Q4;
        rid_pkg::PH_Q4: phase_q <= rid_pkg::PH_Q1;
      endcase
  end

  // Fetch at Q4 overlaps execution; a taken change marks it stale
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_q <= rid_pkg::NOP_WORD;
      flush_q <= 1'b0;
      pc_q <= rid_pkg::PC_RESET;
      sp_q <= rid_pkg::SP_RESET;
    end
    else if (is_q4)
    begin
      ir_q <= instr;
      flush_q <= taken;
      pc_q <= pc_q + 13'h0001;
      if (exec)
        unique case (dec.kind)
          rid_pkg::K_CALL:
          begin
            pc_q <= {page, dec.k11};
            sp_q <= sp_q + 3'h1;
          end
          rid_pkg::K_GOTO: pc_q <= {page, dec.k11};
          rid_pkg::K_RET, rid_pkg::K_RETFIE, rid_pkg::K_RETLW:
          begin
            pc_q <= stack_q[sp_q - 3'h1];
            sp_q <= sp_q - 3'h1;
          end
          default: pc_q <= pc_q + 13'h0001;
        endcase
    end
  end

  // Return stack wraps silently on overflow, like a ring
  always_ff @(posedge clock)
  begin
    if (is_q4 && exec && dec.kind == rid_pkg::K_CALL)
      stack_q[sp_q] <= pc_q;
  end

  // Address in Q2, read in Q3, even for write-only forms
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_addr_q <= 7'h00;
      file_rd_q <= 1'b0;
      port_read_q <= 1'b0;
    end
    else
    begin
      if (phase_q == rid_pkg::PH_Q1)
        file_addr_q <= dec.f;
      file_rd_q <= phase_q == rid_pkg::PH_Q2 && exec
        && dec.use_file;
      // Reading the port clears its change mismatch
      port_read_q <= phase_q == rid_pkg::PH_Q2 && exec
        && dec.use_file && dec.f == rid_pkg::PORT_B_ADDR;
    end
  end

  // Operand capture; the port reads its pins, not its latch
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      opnd_q <= 8'h00;
    else if (file_rd_q)
      opnd_q <= (file_addr_q == rid_pkg::PORT_B_ADDR) ?
        port_b_pins : file_rdata;
  end

  // Store at end of Q4 by destination select
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_we_q <= 1'b0;
      file_wdata_q <= 8'h00;
    end
    else
    begin
      file_we_q <= is_q4 && exec && dec.wr_file;
      if (is_q4)
        file_wdata_q <= alu_res;
    end
  end

  // Accumulator and flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_q <= rid_pkg::ACC_RESET;
      status_q <= rid_pkg::STAT_RESET;
    end
    else if (is_q4 && exec)
    begin
      if (dec.wr_w)
        w_q <= alu_res;
      if (dec.upd[rid_pkg::ST_Z])
        status_q[rid_pkg::ST_Z] <= alu_res == 8'h00;
      if (dec.upd[rid_pkg::ST_DC])
        status_q[rid_pkg::ST_DC] <= alu_dc;
      if (dec.upd[rid_pkg::ST_C])
        status_q[rid_pkg::ST_C] <= alu_c;
    end
  end

  // One-clock control pulses; reserved words raise none
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      evt_q <= '0;
    else
    begin
      evt_q.sleep <= is_q4 && exec && dec.kind == rid_pkg::K_SLEEP;
      evt_q.wdt_clr <= is_q4 && exec && dec.kind == rid_pkg::K_CLRWDT;
      evt_q.int_ret <= is_q4 && exec && dec.kind == rid_pkg::K_RETFIE;
    end
  end

  assign prog_addr = pc_q;
  assign file_addr = file_addr_q;
  assign file_rd = file_rd_q;
  assign port_read = port_read_q;
  assign file_we = file_we_q;
  assign file_wdata = file_wdata_q;
  assign acc = w_q;
  assign status = status_q;
  assign phase = phase_q;
  assign nop_cycle = flush_q;
  assign evt = evt_q;

  phase_order_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    phase_q == rid_pkg::PH_Q1 |=> phase_q == rid_pkg::PH_Q2 ##1
    phase_q == rid_pkg::PH_Q3 ##1 phase_q == rid_pkg::PH_Q4 ##1
    phase_q == rid_pkg::PH_Q1)
  else $error("phase order broken");

  rmw_read_first_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    file_we_q |-> $past(file_rd_q, 2))
  else $error("file write without prior read");

  port_read_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    file_rd_q && file_addr_q == rid_pkg::PORT_B_ADDR |-> port_read_q)
  else $error("port read not flagged");

  port_pins_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    file_rd_q && file_addr_q == rid_pkg::PORT_B_ADDR
    |=> opnd_q == $past(port_b_pins))
  else $error("port operand not pin levels");

  dest_sel_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    is_q4 && exec && dec.kind == rid_pkg::K_BYTE && dec.use_file
    |=> file_we_q == $past(dec.d))
  else $error("destination select ignored");

  addr_field_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    file_rd_q |-> file_addr_q == ir_q[6:0])
  else $error("file address not from operand");

  bit_write_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    file_we_q && $past(ir_q[13:12]) == 2'b01
    |-> file_wdata_q[$past(ir_q[9:7])] == $past(ir_q[10]))
  else $error("wrong bit set or cleared");

  jump_target_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    is_q4 && exec && dec.kind == rid_pkg::K_GOTO
    |=> prog_addr[10:0] == $past(ir_q[10:0]))
  else $error("jump target not eleven-bit literal");

  flush_len_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    is_q4 && taken |=> flush_q [*4] ##1 !flush_q)
  else $error("taken change not one empty cycle");

  empty_slot_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    flush_q && phase_q != rid_pkg::PH_Q1 |-> !file_rd_q && !file_we_q)
  else $error("flushed cycle touched file");
endmodule : rid_core
`default_nettype wire

// ===== hdl/rid_fields.sv
`timescale 1ns/1ps
`default_nettype none
module rid_fields (
  input wire logic [13:0] instr, // Executing word
  output var rid_pkg::rid_dec_t dec // Decoded fields
);
  // Split word into fields and classify
  always_comb
  begin
    dec = '0;
    dec.grp = rid_pkg::GRP_LIT;
    dec.kind = rid_pkg::K_RSVD;
    dec.alu = rid_pkg::A_PASS_B;
    dec.d = instr[7];
    dec.f = instr[6:0];
    dec.b = instr[9:7];
    dec.k8 = instr[7:0];
    dec.k11 = instr[10:0];
    dec.upd = rid_pkg::UPD_NONE;
    unique case (instr[13:12])
      2'b00:
      begin
        if (instr[11:7] == 5'h00)
        begin
          // Idle word ignores bits 6:5
          casez (instr[6:0])
            7'b??0_0000: dec.kind = rid_pkg::K_NOP;
            7'b000_1000: dec.kind = rid_pkg::K_RET;
            7'b000_1001: dec.kind = rid_pkg::K_RETFIE;
            7'b110_0011: dec.kind = rid_pkg::K_SLEEP;
            7'b110_0100: dec.kind = rid_pkg::K_CLRWDT;
            default: dec.kind = rid_pkg::K_RSVD; // Runs as idle
          endcase
        end
        else
        begin
          dec.grp = rid_pkg::GRP_BYTE;
          dec.kind = rid_pkg::K_BYTE;
          // Clear-accumulator form names no file; its f bits ignored
          dec.use_file = !(instr[11:8] == 4'h1 && !instr[7]);
          dec.wr_file = instr[7];
          dec.wr_w = !instr[7];
          dec.upd = rid_pkg::UPD_Z;
          unique case (instr[11:8])
            4'h0:
            begin
              dec.alu = rid_pkg::A_PASS_A;
              dec.upd = rid_pkg::UPD_NONE;
            end
            4'h1: dec.alu = rid_pkg::A_ZERO;
            4'h2:
            begin
              dec.alu = rid_pkg::A_SUB;
              dec.upd = rid_pkg::UPD_ALL;
            end
            4'h3: dec.alu = rid_pkg::A_DEC;
            4'h4: dec.alu = rid_pkg::A_IOR;
            4'h5: dec.alu = rid_pkg::A_AND;
            4'h6: dec.alu = rid_pkg::A_XOR;
            4'h7:
            begin
              dec.alu = rid_pkg::A_ADD;
              dec.upd = rid_pkg::UPD_ALL;
            end
            4'h8: dec.alu = rid_pkg::A_PASS_B;
            4'h9: dec.alu = rid_pkg::A_COM;
            4'ha: dec.alu = rid_pkg::A_INC;
            4'hb:
            begin
              dec.alu = rid_pkg::A_DEC;
              dec.skip_z = 1'b1;
              dec.upd = rid_pkg::UPD_NONE;
            end
            4'hc:
            begin
              dec.alu = rid_pkg::A_RR;
              dec.upd = rid_pkg::UPD_C;
            end
            4'hd:
            begin
              dec.alu = rid_pkg::A_RL;
              dec.upd = rid_pkg::UPD_C;
            end
            4'he:
            begin
              dec.alu = rid_pkg::A_SWAP;
              dec.upd = rid_pkg::UPD_NONE;
            end
            4'hf:
            begin
              dec.alu = rid_pkg::A_INC;
              dec.skip_z = 1'b1;
              dec.upd = rid_pkg::UPD_NONE;
            end
          endcase
        end
      end
      2'b01:
      begin
        dec.grp = rid_pkg::GRP_BIT;
        dec.kind = rid_pkg::K_BIT;
        dec.use_file = 1'b1;
        dec.wr_file = !instr[11];
        dec.alu = instr[10] ? rid_pkg::A_BSET : rid_pkg::A_BCLR;
        dec.skip_bit = instr[11];
        dec.skip_set = instr[10];
      end
      2'b10: dec.kind = instr[11] ? rid_pkg::K_GOTO : rid_pkg::K_CALL;
      2'b11:
      begin
        dec.use_k = 1'b1;
        dec.wr_w = 1'b1;
        dec.kind = rid_pkg::K_LIT;
        dec.upd = rid_pkg::UPD_Z;
        // Don't-care literal bits fall in the wildcards
        unique casez (instr[11:8])
          4'b00??:
          begin
            dec.upd = rid_pkg::UPD_NONE;
          end
          4'b01??:
          begin
            dec.kind = rid_pkg::K_RETLW;
            dec.upd = rid_pkg::UPD_NONE;
          end
          4'b1000: dec.alu = rid_pkg::A_IOR;
          4'b1001: dec.alu = rid_pkg::A_AND;
          4'b1010: dec.alu = rid_pkg::A_XOR;
          4'b1011:
          begin
            dec.kind = rid_pkg::K_RSVD;
            dec.wr_w = 1'b0;
            dec.upd = rid_pkg::UPD_NONE;
          end
          4'b110?:
          begin
            dec.alu = rid_pkg::A_SUB;
            dec.upd = rid_pkg::UPD_ALL;
          end
          4'b111?:
          begin
            dec.alu = rid_pkg::A_ADD;
            dec.upd = rid_pkg::UPD_ALL;
          end
        endcase
      end
    endcase
  end
endmodule : rid_fields
`default_nettype wire

// ===== hdl/rid_pkg.sv
// Contract
// - Instruction is one 14-bit word, opcode plus operands
// - Three groups: byte, bit, literal/control
// - Destination zero writes accumulator, one writes file
// - File operand is 7-bit address 0x00-0x7F
// - Bit operand picks one bit of register
// - Literal is 8-bit data or 11-bit target
// - Don't-care bits never change behaviour
// - Every file instruction reads, modifies, then stores; the bit-test skips here read but store nothing
// - Port read phase counts as a port read
// - Instruction cycle is four oscillator periods
// - One cycle; two when skip or branch taken
// - Unassigned opcodes are reserved, behaviour undefined
// - Port operand is pin levels, not latch
`default_nettype none
package rid_pkg;
  localparam int PC_W = 13;
  localparam int STACK_D = 8;
  localparam logic [6:0] PORT_B_ADDR = 7'h06;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam logic [2:0] UPD_NONE = 3'h0;
  localparam logic [2:0] UPD_C = 3'h1;
  localparam logic [2:0] UPD_Z = 3'h4;
  localparam logic [2:0] UPD_ALL = 3'h7;

  // Four oscillator periods of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rid_phase_t;
  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} rid_grp_t;
  typedef enum logic [3:0] {
    K_BYTE, K_BIT, K_LIT, K_CALL, K_GOTO, K_RET, K_RETFIE,
    K_RETLW, K_SLEEP, K_CLRWDT, K_NOP, K_RSVD
  } rid_kind_t;
  typedef enum logic [3:0] {
    A_PASS_A, A_PASS_B, A_ZERO, A_ADD, A_SUB, A_INC, A_DEC, A_IOR,
    A_AND, A_XOR, A_COM, A_RR, A_RL, A_SWAP, A_BCLR, A_BSET
  } rid_alu_t;

  typedef struct packed {
    rid_grp_t grp;
    rid_kind_t kind;
    rid_alu_t alu;
    logic d;
    logic [6:0] f;
    logic [2:0] b;
    logic [7:0] k8;
    logic [10:0] k11;
    logic use_file;
    logic use_k;
    logic wr_file;
    logic wr_w;
    logic skip_z;
    logic skip_bit;
    logic skip_set;
    logic [2:0] upd;
  } rid_dec_t;

  typedef struct packed {
    logic sleep;
    logic wdt_clr;
    logic int_ret;
  } rid_evt_t;
endpackage : rid_pkg
`default_nettype wire

// ===== verif/rid_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rid_prog_mem (
  input wire logic [12:0] prog_addr, // Fetch address from the core
  output logic [13:0] instr // Word at that address
);
  logic [13:0] mem [64];

  // Only 64 words held; upper address bits alias onto them
  assign instr = mem[prog_addr[5:0]];

  // Empty memory reads as no-operation words
  task automatic clear();
    for (int i = 0; i < 64; i++)
    begin
      mem[i] = 14'h0000;
    end
  endtask : clear
endmodule : rid_prog_mem
`default_nettype wire

// ===== verif/risc_instruction_decoder_14bit_test.sv
`timescale 1ns/1ps
`default_nettype none
module risc_instruction_decoder_14bit_test;
  logic clock;
  logic rstn;
  logic [1:0] page;
  logic [7:0] port_b_pins;
  logic [13:0] instr;
  logic [7:0] file_rdata;
  logic [12:0] prog_addr;
  logic [6:0] file_addr;
  logic file_rd;
  logic port_read;
  logic file_we;
  logic [7:0] file_wdata;
  logic [7:0] acc;
  logic [2:0] status;
  rid_pkg::rid_phase_t phase;
  logic nop_cycle;
  rid_pkg::rid_evt_t evt;
  logic [2:0] evs;
  int evn;
  logic [7:0] regs [128];
  int errors;
  int compares;
  int nops;
  int rds;
  int wes;
  int prd;
  int cyc;
  int gap;
  int cnt;
  int wp;
  logic seen;
  logic [12:0] last_pa;

  rid_core uut (
    .clock(clock), .rstn(rstn), .instr(instr), .page(page),
    .prog_addr(prog_addr), .file_addr(file_addr), .file_rd(file_rd),
    .file_rdata(file_rdata), .port_b_pins(port_b_pins),
    .port_read(port_read), .file_we(file_we), .file_wdata(file_wdata),
    .acc(acc), .status(status), .phase(phase), .nop_cycle(nop_cycle),
    .evt(evt)
  );

  rid_prog_mem pm (
    .prog_addr(prog_addr),
    .instr(instr)
  );

  // File register model answers the read strobe combinationally
  assign file_rdata = regs[file_addr];

  // Clock at 40 MHz
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Write strobe sampled with pre-edge values, like a real register
  always @(posedge clock)
  begin
    if (file_we === 1'b1)
      regs[file_addr] <= file_wdata;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Watches fetch spacing, strobe pairing and flushed cycles
  always @(negedge clock)
  begin
    if (rstn !== 1'b1)
    begin
      seen = 1'b0;
      cnt = 0;
      last_pa = prog_addr;
    end
    else
    begin
      cnt++;
      gap++;
      if (prog_addr !== last_pa)
      begin
        if (seen)
          chk(cnt[7:0], 8'd4, "fetch spacing");
        chk({6'h0, phase}, 8'h00, "phase after fetch");
        seen = 1'b1;
        cnt = 0;
        last_pa = prog_addr;
      end
      if (nop_cycle === 1'b1)
        nops++;
      if (port_read === 1'b1)
        prd++;
      // Control pulses gathered; a reserved word must add none
      evs = evs | evt;
      if (evt !== 3'h0)
        evn++;
      if (file_rd === 1'b1)
      begin
        rds++;
        gap = 0;
        chk({7'h0, nop_cycle}, 8'h00, "read in empty cycle");
        chk({7'h0, port_read}, {7'h0, file_addr === 7'h06}, "port");
      end
      if (file_we === 1'b1)
      begin
        wes++;
        chk(gap[7:0], 8'd2, "read to write gap");
      end
    end
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic boot();
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    pm.clear();
    for (int i = 0; i < 128; i++)
    begin
      regs[i] = 8'h00;
    end
    wp = 0;
    nops = 0;
    rds = 0;
    wes = 0;
    prd = 0;
    evs = 3'h0;
    evn = 0;
  endtask : boot

  task automatic put(input logic [13:0] w);
    pm.mem[wp] = w;
    wp++;
  endtask : put

  // Trailing empty words let the last write land before checking
  task automatic go(input int n);
    @(posedge clock);
    rstn <= 1'b1;
    repeat (4 * n) @(posedge clock);
    @(negedge clock);
  endtask : go

  // Literal load with don't-care bits set, then literal add; carry, nibble carry, zero
  task automatic t_literal();
    boot();
    put(14'h33C3);
    put(14'h3E3D);
    go(8);
    chk(acc, 8'h00, "literal add result");
    chk({5'h0, status}, 8'h07, "literal add flags");
    chk(rds[7:0], 8'd0, "literal touched file");
  endtask : t_literal

  // Both destinations, at both ends of the file address range
  task automatic t_dest();
    boot();
    put(14'h3033);
    put(14'h00FF);
    put(14'h0080);
    put(14'h077F);
    put(14'h0780);
    go(10);
    chk(acc, 8'h66, "add to accumulator");
    chk(regs[127], 8'h33, "top file untouched");
    chk(regs[0], 8'h99, "add to file");
    chk(wes[7:0], 8'd3, "file writes");
  endtask : t_dest

  // Bit set/clear, then taken and untaken skips
  task automatic t_bit();
    boot();
    put(14'h01A0);
    put(14'h17A0);
    put(14'h1420);
    put(14'h1020);
    put(14'h1FA0);
    put(14'h3011);
    put(14'h1F20);
    put(14'h3022);
    put(14'h1B20);
    put(14'h3033);
    go(16);
    chk(regs[32], 8'h80, "bit set and clear");
    chk(acc, 8'h22, "skip outcome");
    chk(nops[7:0], 8'd8, "empty cycle clocks");
  endtask : t_bit

  // Port operand: write-only clear still reads; pins beat the latch
  task automatic t_port();
    boot();
    regs[6] = 8'h3C;
    port_b_pins <= 8'hA5;
    put(14'h0186);
    put(14'h0886);
    put(14'h0806);
    go(9);
    chk(regs[6], 8'hA5, "pins written back");
    chk(acc, 8'hA5, "pins to accumulator");
    chk(rds[7:0], 8'd3, "file reads");
    chk(prd[7:0], 8'd3, "port reads");
    chk(wes[7:0], 8'd2, "port writes");
  endtask : t_port

  // Jump, call and return each flush the prefetched word
  task automatic t_flow();
    boot();
    put(14'h2805);
    put(14'h3099);
    wp = 5;
    put(14'h2020);
    put(14'h3E01);
    wp = 32;
    put(14'h345B);
    go(14);
    chk(acc, 8'h5C, "call and return value");
    chk(nops[7:0], 8'd12, "empty cycle clocks");
  endtask : t_flow

  // Subtract, rotate, swap, increment-skip, both returns, pulses
  task automatic t_misc();
    boot();
    regs[34] = 8'hFF;
    put(14'h3005);
    put(14'h3D15);
    put(14'h00A1);
    put(14'h0DA1);
    put(14'h0E21);
    put(14'h0FA2);
    put(14'h30EE);
    put(14'h2030);
    put(14'h2038);
    put(14'h3840);
    wp = 48;
    put(14'h0063);
    put(14'h0064);
    put(14'h3B00);
    put(14'h0009);
    wp = 56;
    put(14'h0008);
    go(22);
    chk(acc, 8'h52, "sub, rotate, swap, return");
    chk({5'h0, status}, 8'h02, "subtract then rotate flags");
    chk(regs[33], 8'h21, "rotate through carry");
    chk(regs[34], 8'h00, "increment and skip");
    chk(wes[7:0], 8'd3, "file writes");
    chk(nops[7:0], 8'd20, "empty cycle clocks");
    chk({5'h0, evs}, 8'h07, "control pulses");
    chk(evn[7:0], 8'd3, "pulse count");
  endtask : t_misc

  initial
  begin
    errors = 0;
    compares = 0;
    cyc = 0;
    gap = 0;
    rstn = 1'b0;
    page = 2'b00;
    port_b_pins = 8'h00;
    repeat (16) @(posedge clock);
    t_literal();
    t_dest();
    t_bit();
    t_port();
    t_flow();
    t_misc();
    print_verdict();
  end
endmodule : risc_instruction_decoder_14bit_test
`default_nettype wire
